//--- deir_regs.sv
// event enable, queued status and completion irq enable bank with axi4-lite slave
// assumes events, kicks, chains and completions are single-cycle pulses on mclk_i, except ext_evt_i (pin)
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`include "deir_defs.svh"
module deir_regs #(
    parameter int CH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [CH-1:0] ext_evt_i,
    input wire logic [CH-1:0] kick_i,
    input wire logic [CH-1:0] chain_i,
    input wire logic [CH-1:0] done_i,
    input wire logic [CH-1:0] done_irq_req_i,
    input wire logic [CH-1:0] hw_qclr_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [CH-1:0] dispatch_o,
    output logic [CH-1:0] done_irq_o,
    output logic irq_o
);
    typedef struct packed {
        logic [CH-1:0] sync1;
        logic [CH-1:0] sync2;
        logic [CH-1:0] sync3;
        logic [CH-1:0] evt_latch;
        logic [CH-1:0] kick_latch;
        logic [CH-1:0] chain_latch;
        logic [CH-1:0] event_gate_mask;
        logic [CH-1:0] queued_status;
        logic [CH-1:0] completion_irq_mask;
        logic [CH-1:0] done_stat;
        logic [CH-1:0] dispatch;
        logic [CH-1:0] done_irq;
        logic [`DEIR_NSTAT_W-1:0] nstat;
        logic [`DEIR_NSTAT_W-1:0] nmask;
        logic irq;
        logic aw_got;
        logic [11:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        deir_pkg::deir_bus_e rstate;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } deir_state_s;

    deir_state_s s_q, s_d;
    logic [CH-1:0] pend, grant, blocked;
    logic [31:0] wmask, wbits;
    logic wr_fire;

    deir_arbiter #(.CH(CH)) u_arb (
        .pend_i(pend),
        .queued_i(s_q.queued_status),
        .grant_o(grant),
        .blocked_o(blocked)
    );

    // external events count only when enabled; chained and manual ones bypass the mask
    assign pend = (s_q.evt_latch & s_q.event_gate_mask) | s_q.kick_latch | s_q.chain_latch;
    assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign wmask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    assign wbits = s_q.wdata & wmask;

    always_comb begin
        logic [CH-1:0] w1;
        w1 = wbits[CH-1:0];
        s_d = s_q;
        // pin events pass two flops before the edge detect
        s_d.sync1 = ext_evt_i;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        s_d.evt_latch = (s_q.evt_latch & ~grant) | (s_q.sync2 & ~s_q.sync3);
        s_d.kick_latch = (s_q.kick_latch & ~grant) | kick_i;
        s_d.chain_latch = (s_q.chain_latch & ~grant) | chain_i;
        s_d.dispatch = grant;
        s_d.done_stat = s_q.done_stat | done_i;
        s_d.done_irq = done_i & done_irq_req_i & s_q.completion_irq_mask;
        s_d.nstat = s_q.nstat | {(|blocked), (|grant)};
        // write channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `DEIR_RESP_OKAY;
            case ({s_q.awaddr[11:2], 2'b00})
                // mask, queued-status and event-latch words are read-only; only set/clear ports and hardware move them
                `DEIR_OFS_EVT_MASK, `DEIR_OFS_QSTAT, `DEIR_OFS_IRQ_MASK, `DEIR_OFS_EVT_LATCH: begin
                    // writes to read-only words are dropped but still answered okay
                    s_d.bresp = `DEIR_RESP_OKAY;
                end
                `DEIR_OFS_EVT_CLR: s_d.event_gate_mask = s_q.event_gate_mask & ~w1;
                `DEIR_OFS_EVT_SET: s_d.event_gate_mask = s_q.event_gate_mask | w1;
                `DEIR_OFS_QSTAT_CLR: ;
                `DEIR_OFS_IRQ_SET: s_d.completion_irq_mask = s_q.completion_irq_mask | w1;
                `DEIR_OFS_IRQ_CLR: s_d.completion_irq_mask = s_q.completion_irq_mask & ~w1;
                `DEIR_OFS_DONE_STAT: s_d.done_stat = (s_q.done_stat & ~w1) | done_i;
                `DEIR_OFS_NSTAT: s_d.nstat = (s_q.nstat & ~w1[`DEIR_NSTAT_W-1:0]) | {(|blocked), (|grant)};
                `DEIR_OFS_NMASK: s_d.nmask = w1[`DEIR_NSTAT_W-1:0];
                default: s_d.bresp = `DEIR_RESP_SLVERR;
            endcase
        end
        // queued status: software clear and hardware clear, dispatch set wins
        begin
            logic [CH-1:0] qclr;
            qclr = hw_qclr_i;
            if (wr_fire && {s_q.awaddr[11:2], 2'b00} == `DEIR_OFS_QSTAT_CLR) begin
                qclr = qclr | w1;
            end
            s_d.queued_status = (s_q.queued_status & ~qclr) | grant;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        case (s_q.rstate)
            deir_pkg::DEIR_IDLE: begin
                if (s_axi_arvalid) begin
                    s_d.rstate = deir_pkg::DEIR_RESP;
                    s_d.rresp = `DEIR_RESP_OKAY;
                    s_d.rdata = `DEIR_RST_WORD;
                    case ({s_axi_araddr[11:2], 2'b00})
                        `DEIR_OFS_EVT_MASK: s_d.rdata[CH-1:0] = s_q.event_gate_mask;
                        `DEIR_OFS_QSTAT: s_d.rdata[CH-1:0] = s_q.queued_status;
                        `DEIR_OFS_IRQ_MASK: s_d.rdata[CH-1:0] = s_q.completion_irq_mask;
                        `DEIR_OFS_DONE_STAT: s_d.rdata[CH-1:0] = s_q.done_stat;
                        `DEIR_OFS_EVT_LATCH: s_d.rdata[CH-1:0] = s_q.evt_latch;
                        `DEIR_OFS_NSTAT: s_d.rdata[`DEIR_NSTAT_W-1:0] = s_q.nstat;
                        `DEIR_OFS_NMASK: s_d.rdata[`DEIR_NSTAT_W-1:0] = s_q.nmask;
                        // write-only ports read back zero
                        `DEIR_OFS_EVT_CLR, `DEIR_OFS_EVT_SET, `DEIR_OFS_QSTAT_CLR,
                        `DEIR_OFS_IRQ_SET, `DEIR_OFS_IRQ_CLR: s_d.rdata = `DEIR_RST_WORD;
                        default: s_d.rresp = `DEIR_RESP_SLVERR;
                    endcase
                end
            end
            deir_pkg::DEIR_RESP: begin
                if (s_axi_rready) begin
                    s_d.rstate = deir_pkg::DEIR_IDLE;
                end
            end
            default: s_d.rstate = deir_pkg::DEIR_IDLE;
        endcase
        s_d.irq = |(s_d.nstat & s_d.nmask);
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.rstate == deir_pkg::DEIR_IDLE;
    assign s_axi_rvalid = s_q.rstate == deir_pkg::DEIR_RESP;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign dispatch_o = s_q.dispatch;
    assign done_irq_o = s_q.done_irq;
    assign irq_o = s_q.irq;

    a_clr_port_evt: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_fire && {s_q.awaddr[11:2], 2'b00} == `DEIR_OFS_EVT_CLR |=> ((s_q.event_gate_mask & $past(w_one())) == '0))
        else $error("event mask bit survived clear");
    a_set_port_evt: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_fire && {s_q.awaddr[11:2], 2'b00} == `DEIR_OFS_EVT_SET |=> ((s_q.event_gate_mask & $past(w_one())) == $past(w_one())))
        else $error("event mask bit not set");
    a_mask_stable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(wr_fire && ({s_q.awaddr[11:2], 2'b00} inside {`DEIR_OFS_EVT_CLR, `DEIR_OFS_EVT_SET})) |=> $stable(s_q.event_gate_mask))
        else $error("event mask changed without port write");
    a_queue_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        |grant |=> ((s_q.queued_status & $past(grant)) == $past(grant)) && dispatch_o == $past(grant))
        else $error("dispatch did not queue channel");
    a_queue_block: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (grant & s_q.queued_status) == '0)
        else $error("queued channel arbitrated again");
    a_qclr_port: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_fire && {s_q.awaddr[11:2], 2'b00} == `DEIR_OFS_QSTAT_CLR && grant == '0 && hw_qclr_i == '0
        |=> (s_q.queued_status & $past(w_one())) == '0)
        else $error("queued bit not cleared");
    a_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        |(grant & hw_qclr_i) |=> |(s_q.queued_status & $past(grant & hw_qclr_i)))
        else $error("clear beat dispatch set");
    a_irq_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ##1 done_irq_o == ($past(done_i) & $past(done_irq_req_i) & $past(s_q.completion_irq_mask)))
        else $error("completion irq not gated by mask");
    a_irq_mask_ro: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(wr_fire && ({s_q.awaddr[11:2], 2'b00} inside {`DEIR_OFS_IRQ_SET, `DEIR_OFS_IRQ_CLR})) |=> $stable(s_q.completion_irq_mask))
        else $error("irq mask changed without port write");

    function automatic logic [CH-1:0] w_one();
        return wbits[CH-1:0];
    endfunction
endmodule // deir_regs

//--- deir_defs.svh
// register offsets, reset values and field constants for the event/irq enable bank
// assumes a 32-bit axi4-lite slave with 12-bit byte addresses
`ifndef DEIR_DEFS_SVH
`define DEIR_DEFS_SVH
`define DEIR_OFS_EVT_MASK      12'h000
`define DEIR_OFS_EVT_CLR       12'h004
`define DEIR_OFS_EVT_SET       12'h008
`define DEIR_OFS_QSTAT         12'h00c
`define DEIR_OFS_QSTAT_CLR     12'h010
`define DEIR_OFS_IRQ_MASK      12'h014
`define DEIR_OFS_IRQ_SET       12'h018
`define DEIR_OFS_IRQ_CLR       12'h01c
`define DEIR_OFS_DONE_STAT     12'h020
`define DEIR_OFS_EVT_LATCH     12'h024
`define DEIR_OFS_NSTAT         12'h028
`define DEIR_OFS_NMASK         12'h02c
`define DEIR_RST_WORD          32'h0000_0000
`define DEIR_RESP_OKAY         2'b00
`define DEIR_RESP_SLVERR       2'b10
`define DEIR_NSTAT_W           2
`define DEIR_NBIT_DISPATCH     0
`define DEIR_NBIT_BLOCKED      1
`endif

//--- deir_pkg.sv
// types shared by the event/irq enable bank
// assumes deir_defs.svh is included by every user
package deir_pkg;
    typedef logic [31:0] deir_word_t;
    typedef enum logic [1:0] {
        DEIR_IDLE = 2'b00,
        DEIR_RESP = 2'b01
    } deir_bus_e;
endpackage

//--- deir_arbiter.sv
// per-channel dispatch gating: picks the lowest pending channel not yet queued
// assumes all inputs are on mclk_i; one channel dispatched per cycle at most
`include "deir_defs.svh"
module deir_arbiter #(
    parameter int CH = 32
) (
    input wire logic [CH-1:0] pend_i,
    input wire logic [CH-1:0] queued_i,
    output logic [CH-1:0] grant_o,
    output logic [CH-1:0] blocked_o
);
    logic [CH-1:0] elig;
    logic [CH:0] seen;
    assign elig = pend_i & ~queued_i;
    assign blocked_o = pend_i & queued_i;
    assign seen[0] = 1'b0;
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_pick
            assign grant_o[g] = elig[g] & ~seen[g];
            assign seen[g+1] = seen[g] | elig[g];
        end
    endgenerate
endmodule // deir_arbiter

//--- deir_regs_test.sv
// self-checking bench for deir_regs: axi4-lite register traffic plus trigger, completion and irq pins
// assumes deir_defs.svh on the include path; bus answers are awaited, never assumed to take fixed cycles
`include "deir_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module deir_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = `DEIR_RESP_OKAY;
    localparam logic [1:0] SE = `DEIR_RESP_SLVERR;
    logic mclk_i, rst_n_i;
    logic [31:0] ext_evt_i, kick_i, chain_i, done_i, done_irq_req_i, hw_qclr_i;
    logic [11:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, dispatch_o, done_irq_o, dsp, dirq;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic irq_o;
    int n_mismatch = 0;
    int checks_done = 0;

    deir_regs #(.CH(32)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ext_evt_i(ext_evt_i), .kick_i(kick_i),
        .chain_i(chain_i), .done_i(done_i), .done_irq_req_i(done_irq_req_i), .hw_qclr_i(hw_qclr_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .dispatch_o(dispatch_o), .done_irq_o(done_irq_o), .irq_o(irq_o));

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task timeout;
        n_mismatch++;
        $display("CHECK FAILED t=%0t bus answer never came", $time);
        final_report();
    endtask

    // bready/rready stay high for the whole run, so no task ever has to re-raise them in one time step
    task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) timeout();
        `CHK(bresp, er)
    endtask

    task axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) timeout();
        `CHK(rdata, e)
        `CHK(rresp, er)
    endtask

    // one-cycle pulse on the chosen trigger input
    task trig(input int s, input logic [31:0] v);
        case (s)
            0: kick_i <= v;
            1: chain_i <= v;
            2: begin
                done_i <= v;
                done_irq_req_i <= v;
            end
            3: done_i <= v;
            default: hw_qclr_i <= v;
        endcase
        @(posedge mclk_i);
        kick_i <= '0;
        chain_i <= '0;
        done_i <= '0;
        done_irq_req_i <= '0;
        hw_qclr_i <= '0;
    endtask

    // pulses are one cycle wide, so collect them over a window instead of guessing the exact edge
    task watch(input int k);
        dsp = '0;
        dirq = '0;
        repeat (k) begin
            @(posedge mclk_i);
            dsp |= dispatch_o;
            dirq |= done_irq_o;
        end
    endtask

    initial begin
        {rst_n_i, awvalid, wvalid, arvalid} = '0;
        {ext_evt_i, kick_i, chain_i, done_i, done_irq_req_i, hw_qclr_i} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        for (int i = 0; i < 12; i++) axr(12'(4 * i), `DEIR_RST_WORD, OK);
        axw(`DEIR_OFS_EVT_MASK, 32'hffff_ffff, OK);
        axr(`DEIR_OFS_EVT_MASK, 32'h0000_0000, OK);
        axw(`DEIR_OFS_EVT_SET, 32'ha5a5_0003, OK);
        axw(`DEIR_OFS_EVT_SET, 32'h0000_0000, OK);
        axr(`DEIR_OFS_EVT_MASK, 32'ha5a5_0003, OK);
        axw(`DEIR_OFS_EVT_CLR, 32'h0000_0001, OK);
        axw(`DEIR_OFS_EVT_CLR, 32'h0000_0000, OK);
        axr(`DEIR_OFS_EVT_MASK, 32'ha5a5_0002, OK);
        axr(`DEIR_OFS_EVT_SET, 32'h0000_0000, OK);
        axw(`DEIR_OFS_IRQ_MASK, 32'hffff_ffff, OK);
        axw(`DEIR_OFS_IRQ_SET, 32'h0000_0006, OK);
        axw(`DEIR_OFS_IRQ_CLR, 32'h0000_0004, OK);
        axr(`DEIR_OFS_IRQ_MASK, 32'h0000_0002, OK);
        trig(0, 32'h0000_0008);
        watch(8);
        `CHK(dsp, 32'h0000_0008)
        axr(`DEIR_OFS_QSTAT, 32'h0000_0008, OK);
        trig(0, 32'h0000_0008);
        watch(8);
        `CHK(dsp, 32'h0000_0000)
        axw(`DEIR_OFS_QSTAT_CLR, 32'hffff_fff7, OK);
        axr(`DEIR_OFS_QSTAT, 32'h0000_0008, OK);
        axw(`DEIR_OFS_QSTAT_CLR, 32'h0000_0008, OK);
        watch(4);
        `CHK(dsp, 32'h0000_0008)
        trig(4, 32'h0000_0008);
        axr(`DEIR_OFS_QSTAT, 32'h0000_0000, OK);
        ext_evt_i <= 32'h0000_0020;
        watch(10);
        `CHK(dsp, 32'h0000_0000)
        axr(`DEIR_OFS_EVT_LATCH, 32'h0000_0020, OK);
        axw(`DEIR_OFS_EVT_SET, 32'h0000_0020, OK);
        watch(4);
        `CHK(dsp, 32'h0000_0020)
        trig(1, 32'h0000_0080);
        watch(8);
        `CHK(dsp, 32'h0000_0080)
        trig(2, 32'h0000_0006);
        watch(4);
        `CHK(dirq, 32'h0000_0002)
        trig(3, 32'h0000_0002);
        watch(4);
        `CHK(dirq, 32'h0000_0000)
        axw(`DEIR_OFS_IRQ_SET, 32'h8000_0000, OK);
        trig(2, 32'h8000_0002);
        watch(4);
        `CHK(dirq, 32'h8000_0002)
        axr(`DEIR_OFS_DONE_STAT, 32'h8000_0006, OK);
        axw(`DEIR_OFS_DONE_STAT, 32'h0000_0004, OK);
        axr(`DEIR_OFS_DONE_STAT, 32'h8000_0002, OK);
        axw(`DEIR_OFS_NMASK, 32'h0000_0001, OK);
        watch(2);
        `CHK(irq_o, 1'b1)
        axw(`DEIR_OFS_NSTAT, 32'h0000_0003, OK);
        watch(2);
        `CHK(irq_o, 1'b0)
        axw(`DEIR_OFS_NMASK, 32'h0000_0000, OK);
        trig(0, 32'h0000_0200);
        watch(8);
        `CHK(irq_o, 1'b0)
        axr(`DEIR_OFS_NSTAT, 32'h0000_0001, OK);
        axw(`DEIR_OFS_NMASK, 32'h0000_0001, OK);
        watch(2);
        `CHK(irq_o, 1'b1)
        axw(`DEIR_OFS_NSTAT, 32'h0000_0001, OK);
        watch(2);
        `CHK(irq_o, 1'b0)
        axr(12'h100, 32'h0000_0000, SE);
        axw(12'h100, 32'h0000_0001, SE);
        // drop the pin first so the mid-run reset does not see a fresh edge on it
        ext_evt_i <= '0;
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        axr(`DEIR_OFS_EVT_MASK, 32'h0000_0000, OK);
        axr(`DEIR_OFS_QSTAT, 32'h0000_0000, OK);
        axr(`DEIR_OFS_IRQ_MASK, 32'h0000_0000, OK);
        final_report();
    end
endmodule // deir_regs_test
